/* core/port_gpio_pkg.sv */
// Purpose: Shared constants for the eight-pin bidirectional port.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Offsets are byte addresses.
package port_gpio_pkg;
  localparam int PORT_WIDTH = 8;
  localparam int ADDR_WIDTH = 12;
  localparam logic [ADDR_WIDTH-1:0] LATCH_OFFSET = 12'h000;
  localparam logic [ADDR_WIDTH-1:0] DIRECTION_OFFSET = 12'h004;
  localparam logic [ADDR_WIDTH-1:0] INHIBIT_OFFSET = 12'h008;
  localparam int INHIBIT_LOW_BIT = 0;
  localparam int INHIBIT_HIGH_BIT = 1;
  localparam logic [PORT_WIDTH-1:0] DIRECTION_RESET = 8'h00;
  localparam logic [1:0] INHIBIT_RESET = 2'h0;
  localparam logic [31:0] UNDEFINED_READ = 32'h0000_0000;
  localparam int HALF_WIDTH = 4;
endpackage : port_gpio_pkg

/* core/pin_sync_if.sv */
// Purpose: Carries synchronised pin levels between the port modules.
// Assumes: Single clock domain.
// Notes: Producer is the synchroniser, consumer the port core.
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] level;
  modport producer (output level);
  modport consumer (input level);
endinterface : pin_sync_if
`default_nettype wire

/* core/pin_sync.sv */
// Purpose: Two-flop synchroniser for the port pin inputs.
// Assumes: Pins are asynchronous to clk_sys_i.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic [WIDTH-1:0] pin_i,
  pin_sync_if.producer sync
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stable_r;

  always_ff @(posedge clk_sys_i) begin
    meta_r <= pin_i;
    stable_r <= meta_r;
  end

  assign sync.level = stable_r;
endmodule : pin_sync
`default_nettype wire

/* core/bidir_port_c_gpio.sv */
// Purpose: Eight-pin bidirectional general-purpose port with APB registers.
// Assumes: APB slave, zero wait states; pins sampled through two flops.
// Notes: The data latch has no reset, matching the port behaviour.
//
// Summary of operation
// - Eight pins, each latch and direction bit.
// - Output pin drives its latch bit.
// - Input pin reads sampled pin level.
// - Output pin reads latch, not pin.
// - Latch writes always update every bit; the code ignores a write with pstrb_i[0] low.
// - Reset leaves the latch unchanged.
// - Direction one enables driver, kills pulldown.
// - Direction zero disables driver, pin input.
// - Reset clears all direction bits.
// - Two inhibit bits, upper and lower nibble.
// - Clear inhibit enables pulldown on inputs.
// - Inhibit register is write-only, reads undefined.
// - Reset clears both inhibit bits.
// - Global kill forces every pulldown off.
`timescale 1ns/1ps
`default_nettype none
module bidir_port_c_gpio
  import port_gpio_pkg::*;
#(
  parameter int WIDTH = port_gpio_pkg::PORT_WIDTH
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [port_gpio_pkg::ADDR_WIDTH-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic global_pulldown_kill_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] pin_o,
  output logic [WIDTH-1:0] pin_oe_o,
  output logic [WIDTH-1:0] pulldown_en_o
);
  import port_gpio_pkg::*;

  pin_sync_if #(.WIDTH(WIDTH)) sync_bus ();

  pin_sync #(
    .WIDTH(WIDTH)
  ) u_pin_sync (
    .clk_sys_i(clk_sys_i),
    .pin_i(pin_i),
    .sync(sync_bus.producer)
  );

  // Bus phase as seen at the last edge; the codes change one bit at a time along idle, setup, access.
  typedef enum logic [1:0] {
    PHASE_IDLE = 2'b00,
    PHASE_SETUP = 2'b01,
    PHASE_ACCESS = 2'b11
  } bus_phase_t;

  // Register targeted by the current address.
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_LATCH = 2'b01,
    SEL_DIRECTION = 2'b10,
    SEL_INHIBIT = 2'b11
  } reg_sel_t;

  logic [WIDTH-1:0] pin_latch_register_r;
  logic [WIDTH-1:0] pin_direction_register_r;
  logic upper_nibble_pulldown_inhibit_r;
  logic lower_nibble_pulldown_inhibit_r;
  logic kill_meta_r;
  logic kill_r;
  bus_phase_t phase_r;
  bus_phase_t phase_nxt;
  reg_sel_t sel;
  logic setup_now;
  logic access;
  logic wr_en;
  logic latch_wr;
  logic direction_wr;
  logic inhibit_wr;
  logic [WIDTH-1:0] group_pull;
  logic [WIDTH-1:0] drive_nxt;
  logic [WIDTH-1:0] pulldown_nxt;
  logic [WIDTH-1:0] readback;
  logic [31:0] read_nxt;

  // Maps a byte address onto one of the three registers.
  function automatic reg_sel_t decode_sel(
    input logic [ADDR_WIDTH-1:0] addr
  );
    reg_sel_t result;
    result = SEL_NONE;
    case (addr)
      LATCH_OFFSET: begin
        result = SEL_LATCH;
      end
      DIRECTION_OFFSET: begin
        result = SEL_DIRECTION;
      end
      INHIBIT_OFFSET: begin
        result = SEL_INHIBIT;
      end
      default: begin
        result = SEL_NONE;
      end
    endcase
    return result;
  endfunction : decode_sel

  // Only byte lane 0 carries port data.
  function automatic logic [WIDTH-1:0] low_lane(
    input logic [31:0] word
  );
    return word[WIDTH-1:0];
  endfunction : low_lane

  // Value put on a pin; zero where the pin is an input.
  function automatic logic [WIDTH-1:0] drive_value(
    input logic [WIDTH-1:0] latch,
    input logic [WIDTH-1:0] dir
  );
    return latch & dir;
  endfunction : drive_value

  // One inhibit bit serves each half of the port.
  function automatic logic [WIDTH-1:0] nibble_pulldown(
    input logic inhibit_hi,
    input logic inhibit_lo
  );
    logic [WIDTH-1:0] result;
    result = '0;
    for (int i = 0; i < WIDTH; i++) begin
      if (i >= HALF_WIDTH) begin
        result[i] = ~inhibit_hi;
      end else begin
        result[i] = ~inhibit_lo;
      end
    end
    return result;
  endfunction : nibble_pulldown

  // Outputs read back their latch, inputs the synchronised pin level.
  function automatic logic [WIDTH-1:0] port_readback(
    input logic [WIDTH-1:0] latch,
    input logic [WIDTH-1:0] dir,
    input logic [WIDTH-1:0] level
  );
    return drive_value(latch, dir) | (level & ~dir);
  endfunction : port_readback

  // Word returned for a read of the selected register.
  function automatic logic [31:0] read_word(
    input reg_sel_t target,
    input logic [WIDTH-1:0] port_bits,
    input logic [WIDTH-1:0] dir_bits
  );
    logic [31:0] result;
    result = 32'h0000_0000;
    case (target)
      SEL_LATCH: begin
        result[WIDTH-1:0] = port_bits;
      end
      SEL_DIRECTION: begin
        result[WIDTH-1:0] = dir_bits;
      end
      SEL_INHIBIT: begin
        result = UNDEFINED_READ;
      end
      default: begin
        result = 32'h0000_0000;
      end
    endcase
    return result;
  endfunction : read_word

  assign sel = decode_sel(paddr_i);
  assign setup_now = psel_i & ~penable_i;
  // A transfer is taken only in the cycle that follows an accepted setup cycle, so a held enable acts once.
  assign access = psel_i & penable_i & (phase_r == PHASE_SETUP);
  assign wr_en = access & pwrite_i & pstrb_i[0];
  assign latch_wr = wr_en & (sel == SEL_LATCH);
  assign direction_wr = wr_en & (sel == SEL_DIRECTION);
  assign inhibit_wr = wr_en & (sel == SEL_INHIBIT);

  always_comb begin
    phase_nxt = PHASE_IDLE;
    case (phase_r)
      PHASE_IDLE: begin
        if (setup_now) begin
          phase_nxt = PHASE_SETUP;
        end
      end
      PHASE_SETUP: begin
        if (psel_i && penable_i) begin
          phase_nxt = PHASE_ACCESS;
        end else if (setup_now) begin
          phase_nxt = PHASE_SETUP;
        end
      end
      PHASE_ACCESS: begin
        if (setup_now) begin
          phase_nxt = PHASE_SETUP;
        end
      end
      default: begin
        phase_nxt = PHASE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      phase_r <= PHASE_IDLE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // The kill option is a static strap but still enters through two flops.
  always_ff @(posedge clk_sys_i) begin
    kill_meta_r <= global_pulldown_kill_i;
    kill_r <= kill_meta_r;
  end

  // The latch is written regardless of direction and is never reset.
  always_ff @(posedge clk_sys_i) begin
    if (latch_wr) begin
      pin_latch_register_r <= low_lane(pwdata_i);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      pin_direction_register_r <= DIRECTION_RESET;
    end else if (direction_wr) begin
      pin_direction_register_r <= low_lane(pwdata_i);
    end
  end

  // The inhibit bits cannot be read back, so software must keep its own copy.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      upper_nibble_pulldown_inhibit_r <= INHIBIT_RESET[INHIBIT_HIGH_BIT];
    end else if (inhibit_wr) begin
      upper_nibble_pulldown_inhibit_r <= pwdata_i[INHIBIT_HIGH_BIT];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      lower_nibble_pulldown_inhibit_r <= INHIBIT_RESET[INHIBIT_LOW_BIT];
    end else if (inhibit_wr) begin
      lower_nibble_pulldown_inhibit_r <= pwdata_i[INHIBIT_LOW_BIT];
    end
  end

  assign group_pull = nibble_pulldown(upper_nibble_pulldown_inhibit_r, lower_nibble_pulldown_inhibit_r);

  // A driven pin never pulls down as well.
  always_comb begin
    pulldown_nxt = group_pull & ~pin_direction_register_r;
    if (kill_r) begin
      pulldown_nxt = '0;
    end
  end

  // Reset makes every pin an input with its pulldown on, unless the kill holds them all off.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      if (kill_r) begin
        pulldown_en_o <= '0;
      end else begin
        pulldown_en_o <= '1;
      end
    end else begin
      pulldown_en_o <= pulldown_nxt;
    end
  end

  // Outputs hold zero where a pin is an input, so a stray enable shows a low.
  assign drive_nxt = drive_value(pin_latch_register_r, pin_direction_register_r);
  assign readback = port_readback(pin_latch_register_r, pin_direction_register_r, sync_bus.level);
  assign read_nxt = read_word(sel, readback, pin_direction_register_r);

  // Pin drive registers follow the control registers one edge later.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      pin_oe_o <= '0;
    end else begin
      pin_oe_o <= pin_direction_register_r;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      pin_o <= '0;
    end else begin
      pin_o <= drive_nxt;
    end
  end

  // Zero wait states: pready is registered high for the cycle after an accepted setup cycle.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= (phase_nxt == PHASE_SETUP);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      pslverr_o <= 1'b0;
    end else begin
      pslverr_o <= (phase_nxt == PHASE_SETUP) && (sel == SEL_NONE);
    end
  end

  // Read data stands for the answering cycle and the cycle after it, and reads zero otherwise.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (setup_now && !pwrite_i) begin
      prdata_o <= read_nxt;
    end else if (access && !pwrite_i) begin
      prdata_o <= prdata_o;
    end else begin
      prdata_o <= 32'h0000_0000;
    end
  end
endmodule : bidir_port_c_gpio
`default_nettype wire

/* tb/port_gpio_asserts.sv */
// Purpose: Port pin and bus timing checks.
// Assumes: Zero-wait APB slave.
// Notes: Bound into the port.
`timescale 1ns/1ps
`default_nettype none
module port_gpio_asserts (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [port_gpio_pkg::ADDR_WIDTH-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic global_pulldown_kill_i,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic [7:0] pulldown_en_o
);
  import port_gpio_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  sequence wr_at(logic [ADDR_WIDTH-1:0] a);
    psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0] && paddr_i == a;
  endsequence
  a_ready_setup: assert property (psel_i && !penable_i |=> pready_o) else $error("no ready");
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("long ready");
  a_err_ready: assert property (pslverr_o |-> pready_o) else $error("lone error");
  a_latch_drive: assert property (wr_at(LATCH_OFFSET) |-> ##2 pin_o == ($past(pwdata_i[7:0], 2) & pin_oe_o))
    else $error("bad drive");
  a_dir_oe: assert property (wr_at(DIRECTION_OFFSET) |-> ##2 pin_oe_o == $past(pwdata_i[7:0], 2))
    else $error("bad enable");
  a_input_quiet: assert property ((pin_o & ~pin_oe_o) == 8'h00) else $error("input driven");
  a_out_no_pull: assert property ((pulldown_en_o & pin_oe_o) == 8'h00) else $error("pull on out");
  a_kill_off: assert property (global_pulldown_kill_i [*4] |-> pulldown_en_o == 8'h00) else $error("kill");
  a_reset_dir: assert property ($rose(rstn_i) |-> pin_oe_o == 8'h00) else $error("reset dir");
endmodule : port_gpio_asserts
bind bidir_port_c_gpio port_gpio_asserts i_chk (.clk_sys_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .pstrb_i, .pready_o, .pslverr_o, .global_pulldown_kill_i, .pin_o, .pin_oe_o, .pulldown_en_o);
`default_nettype wire

/* tb/port_pins_model.sv */
// Purpose: Board model of the eight pins.
// Assumes: The port's own drive wins.
// Notes: A bare pin toggles each cycle.
`timescale 1ns/1ps
`default_nettype none
module port_pins_model (
  input wire logic clk_sys_i,
  input wire logic [7:0] out_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] pd_i,
  input wire logic [7:0] drv_i,
  input wire logic [7:0] drv_en_i,
  output logic [7:0] level_o
);
  logic [7:0] float_r = 8'h55;
  always_ff @(posedge clk_sys_i) begin
    float_r <= ~float_r;
  end
  assign level_o = (oe_i & out_i) | (~oe_i & ((drv_en_i & drv_i) | (~drv_en_i & ~pd_i & float_r)));
endmodule : port_pins_model
`default_nettype wire

/* tb/tb_bidir_port_c_gpio.sv */
// Purpose: Register and pin tests of the port.
// Assumes: Zero-wait APB.
// Notes: Latch kept over reset.
`timescale 1ns/1ps
`default_nettype none
module tb_bidir_port_c_gpio;
  import port_gpio_pkg::*;
  logic clk_sys_i = 1'b0, rstn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, kill = 1'b0;
  logic [ADDR_WIDTH-1:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, rd;
  logic pready_o, pslverr_o, err;
  logic [7:0] pin_i, pin_o, pin_oe_o, pd, drv = 8'h00, drv_en = 8'h00;
  logic [3:0] strb = 4'hF;
  int bad_count = 0, n_compared = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  bidir_port_c_gpio i_dut (.clk_sys_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pstrb_i(strb), .prdata_o, .pready_o, .pslverr_o, .global_pulldown_kill_i(kill), .pin_i, .pin_o,
    .pin_oe_o, .pulldown_en_o(pd));
  port_pins_model i_pins (.clk_sys_i, .out_i(pin_o), .oe_i(pin_oe_o), .pd_i(pd), .drv_i(drv),
    .drv_en_i(drv_en), .level_o(pin_i));
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic apb(input logic w, input logic [ADDR_WIDTH-1:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
  endtask : apb
  task automatic rst();
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
  endtask : rst
  initial begin
    #300000;
    bad_count++;
    finish_test();
  end
  initial begin
    rst();
    chk(pin_oe_o, 8'h00);
    chk(pd, 8'hFF);
    apb(1, LATCH_OFFSET, 32'hA5);
    drv <= 8'h30;
    drv_en <= 8'hF0;
    apb(1, DIRECTION_OFFSET, 32'h0F);
    apb(0, LATCH_OFFSET, 0);
    chk(rd, 32'h35);
    chk({pin_oe_o, pin_o, pd}, 24'h0F05F0);
    apb(1, INHIBIT_OFFSET, 32'h2);
    chk(pd, 8'h00);
    apb(0, INHIBIT_OFFSET, 0);
    chk(rd, UNDEFINED_READ);
    apb(1, INHIBIT_OFFSET, 32'h0);
    apb(1, DIRECTION_OFFSET, 32'h00);
    chk({pin_oe_o, pd}, 16'h00FF);
    apb(1, INHIBIT_OFFSET, 32'h1);
    chk(pd, 8'hF0);
    apb(0, 12'h00C, 32'h0);
    chk({rd, err}, 33'h1);
    drv_en <= 8'h00;
    rst();
    chk({pin_oe_o, pd}, 16'h00FF);
    apb(1, DIRECTION_OFFSET, 32'hFF);
    chk(pin_o, 8'hA5);
    apb(0, LATCH_OFFSET, 0);
    chk(rd, 32'hA5);
    apb(1, DIRECTION_OFFSET, 32'h00);
    strb <= 4'h0;
    apb(1, DIRECTION_OFFSET, 32'hFF);
    strb <= 4'hF;
    apb(0, DIRECTION_OFFSET, 0);
    chk(rd, 32'h00);
    kill <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    chk(pd, 8'h00);
    rst();
    chk(pd, 8'h00);
    finish_test();
  end
endmodule : tb_bidir_port_c_gpio
`default_nettype wire
